/* include/dtvm_pkg.sv */
`default_nettype none
package dtvm_pkg;
   // Mode-register addresses served here
   localparam logic [5:0] ADDR_CTRL  = 6'h0D;
   localparam logic [5:0] ADDR_DQREF = 6'h0E;
   localparam logic [5:0] ADDR_INV   = 6'h0F;

   // Control register field positions
   localparam int BIT_CBT  = 0;
   localparam int BIT_RPT  = 1;
   localparam int BIT_VRO  = 2;
   localparam int BIT_FAST = 3;
   localparam int BIT_RRO  = 4;
   localparam int BIT_DMD  = 5;
   localparam int BIT_ASP  = 6;
   localparam int BIT_OSP  = 7;

   // DQ reference register layout
   localparam int LEVEL_W   = 6;
   localparam int REF_W     = 7;
   localparam int BIT_RANGE = 6;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX = 6'h32;

   // Reset values
   localparam logic [7:0]       CTRL_RST  = 8'h00;
   localparam logic [REF_W-1:0] DQREF_RST = 7'h5D;
   localparam logic [7:0]       INV_RST   = 8'h55;

   // Refresh-rate codes touched by the rate option
   localparam logic [2:0] RATE_SUBST = 3'h3;
   localparam logic [2:0] RATE_HIDE1 = 3'h1;
   localparam logic [2:0] RATE_HIDE2 = 3'h2;

   // Pin widths and set-point count
   localparam int CA_W   = 6;
   localparam int DQ_W   = 16;
   localparam int BYTE_W = 8;
   localparam int NUM_SP = 2;
endpackage
`default_nettype wire

/* hdl/dtvm_fsp_copy.sv */
`default_nettype none
// One physical copy of a set-point register
module dtvm_fsp_copy #(
   parameter int         W   = 7,
   parameter logic [6:0] RST = 7'h00
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   // Write port
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wd_i,
   // Stored value
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] val;
   } dtvm_copy_t;

   dtvm_copy_t state_ff;
   dtvm_copy_t nxt_state;

   // Refuse widths that the reset value cannot cover
   if (W < 1 || W > 7) begin : g_bad_width
      $error("dtvm_fsp_copy: W out of range");
   end

   always_comb begin
      nxt_state = state_ff;
      if (wr_i) begin
         nxt_state.val = wd_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff.val <= RST[W-1:0];
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign q_o = state_ff.val;
endmodule
`default_nettype wire

/* hdl/dtvm_regs.sv */
`default_nettype none
module dtvm_regs (
   // Clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_i,
   // Decoded command bus
   input  wire logic                        mrw_i,
   input  wire logic                        mrr_i,
   input  wire logic [5:0]                  ma_i,
   input  wire logic [7:0]                  op_i,
   input  wire logic                        cke_i,
   input  wire logic [dtvm_pkg::CA_W-1:0]   ca_i,
   // Device status inputs
   input  wire logic                        rro_capable_i,
   input  wire logic [2:0]                  temp_rate_i,
   input  wire logic [dtvm_pkg::REF_W-1:0]  ca_ref_sp0_i,
   input  wire logic [dtvm_pkg::REF_W-1:0]  ca_ref_sp1_i,
   // Write mask and calibration path
   input  wire logic [1:0]                  wr_mask_i,
   input  wire logic                        calib_rd_i,
   input  wire logic                        calib_bit_i,
   input  wire logic                        dbi_rd_en_i,
   // DQ bus
   output logic      [dtvm_pkg::DQ_W-1:0]   dq_o,
   output logic                             dq_oe_o,
   output logic                             mrr_valid_o,
   output logic                             lower_mask_inversion_pin_o,
   output logic                             rd_dbi_o,
   // Operating controls
   output logic                             command_bus_training_o,
   output logic                             cmd_ignore_o,
   output logic                             read_preamble_training_o,
   output logic                             reference_level_output_o,
   output logic                             fast_reference_current_o,
   output logic                             mask_disable_o,
   output logic                             access_set_point_select_o,
   output logic                             operating_set_point_select_o,
   output logic      [dtvm_pkg::LEVEL_W-1:0] dq_reference_level_o,
   output logic                             dq_reference_range_o,
   output logic      [2:0]                  refresh_rate_o,
   output logic      [1:0]                  wr_mask_o
);
   typedef struct packed {
      logic [7:0]                  ctrl;
      logic [7:0]                  inv;
      logic [dtvm_pkg::REF_W-1:0]  act_ref;
      logic [dtvm_pkg::DQ_W-1:0]   dq;
      logic                        dq_oe;
      logic                        mrr_valid;
      logic                        dmi;
      logic                        rd_dbi;
      logic                        ignore;
      logic [2:0]                  rate;
      logic [1:0]                  mask;
   } dtvm_state_t;

   dtvm_state_t state_ff;
   dtvm_state_t nxt_state;

   logic [dtvm_pkg::NUM_SP-1:0]                      copy_wr;
   logic [dtvm_pkg::NUM_SP-1:0][dtvm_pkg::REF_W-1:0] copy_q;
   logic                                             ign;
   logic                                             ref_wr;
   logic                                             asp;
   logic                                             osp;
   logic [dtvm_pkg::REF_W-1:0]                       ca_ref_act;

   assign asp = state_ff.ctrl[dtvm_pkg::BIT_ASP];
   assign osp = state_ff.ctrl[dtvm_pkg::BIT_OSP];
   // Training with CKE low swallows every command
   assign ign = state_ff.ctrl[dtvm_pkg::BIT_CBT] & ~cke_i;
   // Reserved level codes are refused whole
   assign ref_wr = mrw_i && !ign && (ma_i == dtvm_pkg::ADDR_DQREF)
                   && (op_i[dtvm_pkg::LEVEL_W-1:0] <= dtvm_pkg::LEVEL_MAX);
   assign ca_ref_act = osp ? ca_ref_sp1_i : ca_ref_sp0_i;

   // One copy per set point, the write lands in the access copy
   for (genvar g = 0; g < dtvm_pkg::NUM_SP; g++) begin : g_sp
      assign copy_wr[g] = ref_wr && (asp == 1'(g));
      dtvm_fsp_copy #(
         .W   (dtvm_pkg::REF_W),
         .RST (dtvm_pkg::DQREF_RST)
      ) u_copy (
         .clock_i (clock_i),
         .rst_i   (rst_i),
         .wr_i    (copy_wr[g]),
         .wd_i    (op_i[dtvm_pkg::REF_W-1:0]),
         .q_o     (copy_q[g])
      );
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_state.ignore    = ign;
      nxt_state.mrr_valid = 1'b0;
      nxt_state.rd_dbi    = dbi_rd_en_i;
      if (mrw_i && !ign) begin
         if (ma_i == dtvm_pkg::ADDR_CTRL) begin
            nxt_state.ctrl = op_i;
         end else if (ma_i == dtvm_pkg::ADDR_INV) begin
            nxt_state.inv = op_i;
         end
      end
      // Operation follows the operating copy only
      nxt_state.act_ref = copy_q[osp];
      // Refresh-rate report
      nxt_state.rate = temp_rate_i;
      if (rro_capable_i && !state_ff.ctrl[dtvm_pkg::BIT_RRO]) begin
         if (temp_rate_i == dtvm_pkg::RATE_HIDE1 ||
             temp_rate_i == dtvm_pkg::RATE_HIDE2) begin
            nxt_state.rate = dtvm_pkg::RATE_SUBST;
         end
      end
      // Mask patterns dropped when masking is disabled
      nxt_state.mask = state_ff.ctrl[dtvm_pkg::BIT_DMD] ? 2'h0 : wr_mask_i;
      // DQ bus source, highest priority first
      nxt_state.dq    = '0;
      nxt_state.dq_oe = 1'b0;
      nxt_state.dmi   = 1'b0;
      if (ign) begin
         nxt_state.dq[dtvm_pkg::CA_W-1:0] = ca_i;
         nxt_state.dq_oe = 1'b1;
      end else if (mrr_i && (ma_i == dtvm_pkg::ADDR_CTRL ||
                             ma_i == dtvm_pkg::ADDR_DQREF ||
                             ma_i == dtvm_pkg::ADDR_INV)) begin
         nxt_state.mrr_valid = 1'b1;
         nxt_state.dq_oe     = 1'b1;
         if (ma_i == dtvm_pkg::ADDR_DQREF) begin
            nxt_state.dq[dtvm_pkg::REF_W-1:0] = copy_q[asp];
         end
      end else if (calib_rd_i) begin
         nxt_state.dq[dtvm_pkg::BYTE_W-1:0] =
            {dtvm_pkg::BYTE_W{calib_bit_i}} ^ state_ff.inv;
         nxt_state.dmi    = calib_bit_i;
         nxt_state.rd_dbi = 1'b0;
         nxt_state.dq_oe  = 1'b1;
      end else if (state_ff.ctrl[dtvm_pkg::BIT_VRO]) begin
         nxt_state.dq = {1'b0, ca_ref_act, 1'b0, copy_q[osp]};
         nxt_state.dq_oe = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff.ctrl      <= dtvm_pkg::CTRL_RST;
         state_ff.inv       <= dtvm_pkg::INV_RST;
         state_ff.act_ref   <= dtvm_pkg::DQREF_RST;
         state_ff.dq        <= '0;
         state_ff.dq_oe     <= 1'b0;
         state_ff.mrr_valid <= 1'b0;
         state_ff.dmi       <= 1'b0;
         state_ff.rd_dbi    <= 1'b0;
         state_ff.ignore    <= 1'b0;
         state_ff.rate      <= 3'h0;
         state_ff.mask      <= 2'h0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign dq_o                       = state_ff.dq;
   assign dq_oe_o                    = state_ff.dq_oe;
   assign mrr_valid_o                = state_ff.mrr_valid;
   assign lower_mask_inversion_pin_o = state_ff.dmi;
   assign rd_dbi_o                   = state_ff.rd_dbi;
   assign command_bus_training_o     = state_ff.ctrl[dtvm_pkg::BIT_CBT];
   assign cmd_ignore_o               = state_ff.ignore;
   assign read_preamble_training_o   = state_ff.ctrl[dtvm_pkg::BIT_RPT];
   assign reference_level_output_o   = state_ff.ctrl[dtvm_pkg::BIT_VRO];
   assign fast_reference_current_o   = state_ff.ctrl[dtvm_pkg::BIT_FAST];
   assign mask_disable_o             = state_ff.ctrl[dtvm_pkg::BIT_DMD];
   assign access_set_point_select_o  = asp;
   assign operating_set_point_select_o = osp;
   assign dq_reference_level_o =
      state_ff.act_ref[dtvm_pkg::LEVEL_W-1:0];
   assign dq_reference_range_o = state_ff.act_ref[dtvm_pkg::BIT_RANGE];
   assign refresh_rate_o       = state_ff.rate;
   assign wr_mask_o            = state_ff.mask;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   ctrl_reset_a: assert property (
      $past(rst_i) |-> (state_ff.ctrl == dtvm_pkg::CTRL_RST)
         && (state_ff.inv == dtvm_pkg::INV_RST)
         && (copy_q[0] == dtvm_pkg::DQREF_RST))
      else $error("control defaults missing after reset");

   ctrl_write_a: assert property (
      (mrw_i && !ign && ma_i == dtvm_pkg::ADDR_CTRL) |=>
         operating_set_point_select_o == $past(op_i[7])
         && access_set_point_select_o == $past(op_i[6])
         && mask_disable_o == $past(op_i[5])
         && command_bus_training_o == $past(op_i[0]))
      else $error("control write not applied");

   cbt_ignore_a: assert property (
      (command_bus_training_o && !cke_i) |=>
         cmd_ignore_o && dq_oe_o && !mrr_valid_o
         && dq_o[5:0] == $past(ca_i) && $stable(state_ff.ctrl))
      else $error("training did not mirror CA or ignore commands");

   level_rsvd_a: assert property (
      (mrw_i && ma_i == dtvm_pkg::ADDR_DQREF
         && op_i[5:0] > dtvm_pkg::LEVEL_MAX) |=> $stable(copy_q))
      else $error("reserved reference level accepted");

   ref_read_a: assert property (
      (mrr_i && !ign && ma_i == dtvm_pkg::ADDR_DQREF) |=>
         mrr_valid_o && dq_o[15:7] == 9'h000
         && dq_o[6:0] == $past(copy_q[asp]))
      else $error("reference readback wrong");

   rate_subst_a: assert property (
      (rro_capable_i && !state_ff.ctrl[dtvm_pkg::BIT_RRO]
         && temp_rate_i inside {3'h1, 3'h2}) |=> refresh_rate_o == 3'h3)
      else $error("hidden refresh code reported");

   rate_pass_a: assert property (
      (!rro_capable_i || state_ff.ctrl[dtvm_pkg::BIT_RRO]) |=>
         refresh_rate_o == $past(temp_rate_i))
      else $error("refresh code altered without option");

   mask_drop_a: assert property (
      mask_disable_o |=> wr_mask_o == 2'h0)
      else $error("mask applied while disabled");

   calib_inv_a: assert property (
      (calib_rd_i && !ign && !mrr_i) |=>
         dq_o[7:0] == ({8{$past(calib_bit_i)}} ^ $past(state_ff.inv))
         && lower_mask_inversion_pin_o == $past(calib_bit_i) && !rd_dbi_o)
      else $error("calibration pattern inversion wrong");

   sp_switch_a: assert property (
      ($changed(operating_set_point_select_o) && !ref_wr) |=>
         dq_reference_level_o == copy_q[$past(osp)][5:0])
      else $error("operating copy not followed");

   ctrl_bits_a: assert property (
      (mrw_i && !ign && ma_i == dtvm_pkg::ADDR_CTRL) |=>
         read_preamble_training_o == $past(op_i[dtvm_pkg::BIT_RPT])
         && reference_level_output_o == $past(op_i[dtvm_pkg::BIT_VRO])
         && fast_reference_current_o == $past(op_i[dtvm_pkg::BIT_FAST]))
      else $error("training or reference control bit not applied");

   ctrl_hold_a: assert property (
      !(mrw_i && !ign && ma_i == dtvm_pkg::ADDR_CTRL) |=>
         $stable(state_ff.ctrl))
      else $error("control register changed without a write");

   inv_write_a: assert property (
      (mrw_i && !ign && ma_i == dtvm_pkg::ADDR_INV) |=>
         state_ff.inv == $past(op_i))
      else $error("invert register write not applied");

   wo_read_a: assert property (
      (mrr_i && !ign && (ma_i == dtvm_pkg::ADDR_CTRL
         || ma_i == dtvm_pkg::ADDR_INV)) |=>
         mrr_valid_o && dq_oe_o && dq_o == '0)
      else $error("write-only register read did not return zero");

   ref_reset_a: assert property (
      $past(rst_i) |-> (copy_q[1] == dtvm_pkg::DQREF_RST)
         && (state_ff.act_ref == dtvm_pkg::DQREF_RST))
      else $error("reference default missing after reset");

   copy_hold_a: assert property (
      !ref_wr |=> $stable(copy_q))
      else $error("reference copy changed without a write");

   inactive_copy_a: assert property (
      (ref_wr && asp != osp) |-> ##2 $stable(state_ff.act_ref))
      else $error("inactive copy write reached operation");

   vro_drive_a: assert property (
      (reference_level_output_o && !ign && !mrr_i && !calib_rd_i) |=>
         dq_oe_o && dq_o == {1'b0, $past(ca_ref_act), 1'b0,
                             $past(copy_q[osp])})
      else $error("reference levels not driven on DQ");

   dbi_pass_a: assert property (
      !calib_rd_i |=> rd_dbi_o == $past(dbi_rd_en_i))
      else $error("read inversion enable not passed through");

   dq_idle_a: assert property (
      (!ign && !mrr_i && !calib_rd_i && !reference_level_output_o) |=>
         !dq_oe_o && dq_o == '0 && !lower_mask_inversion_pin_o)
      else $error("DQ driven while idle");
endmodule
`default_nettype wire

/* verif/dtvm_ctrl_model.sv */
`default_nettype none
// Controller side: issues mode-register writes and reads
module dtvm_ctrl_model (
   // Clock
   input  wire logic       clock_i,
   // Command bus towards the device
   output logic            mrw_o,
   output logic            mrr_o,
   output logic      [5:0] ma_o,
   output logic      [7:0] op_o,
   output logic            cke_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      mrw_o = 1'b0;
      mrr_o = 1'b0;
      ma_o  = 6'h3F;
      op_o  = 8'hFF;
      cke_o = 1'b1;
   end

   // One command for one edge; the released bus shows inverted address and data values
   task automatic cmd(input logic w, input logic [5:0] ma,
                      input logic [7:0] op);
      @(posedge clock_i);
      mrw_o <= w;
      mrr_o <= !w;
      ma_o  <= ma;
      op_o  <= op;
      @(posedge clock_i);
      mrw_o <= 1'b0;
      mrr_o <= 1'b0;
      ma_o  <= ~ma;
      op_o  <= ~op;
      #1;
   endtask

   task automatic set_cke(input logic v);
      @(posedge clock_i);
      cke_o <= v;
   endtask

   // Clock enable goes high before the training bit is cleared
   task automatic leave_training();
      @(posedge clock_i);
      cke_o <= 1'b1;
      cmd(1'b1, 6'h0D, 8'h00);
   endtask
endmodule
`default_nettype wire

/* verif/dram_training_vref_mode_regs_bench.sv */
`default_nettype none
module dram_training_vref_mode_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        mrw_i, mrr_i, cke_i;
   logic [5:0]  ma_i;
   logic [7:0]  op_i;
   logic [5:0]  ca_i = 6'h00;
   logic        rro_capable_i = 1'b0;
   logic [2:0]  temp_rate_i = 3'h0;
   logic [6:0]  ca_ref_sp0_i = 7'h00;
   logic [6:0]  ca_ref_sp1_i = 7'h00;
   logic [1:0]  wr_mask_i = 2'h0;
   logic        calib_rd_i = 1'b0;
   logic        calib_bit_i = 1'b0;
   logic        dbi_rd_en_i = 1'b0;
   logic [15:0] dq_o;
   logic        dq_oe_o, mrr_valid_o, pin_o, rd_dbi_o, cbt_o, ign_o;
   logic        rpt_o, vro_o, fast_o, dmd_o, asp_o, osp_o, range_o;
   logic [5:0]  level_o;
   logic [2:0]  refresh_rate_o;
   logic [1:0]  wr_mask_o;
   logic [7:0]  ctl;
   int          error_cnt = 0;
   int          cmp_count = 0;

   assign ctl = {osp_o, asp_o, dmd_o, 1'b0, fast_o, vro_o, rpt_o, cbt_o};
   always #4 clock_i = ~clock_i;

   dtvm_ctrl_model m (.clock_i(clock_i), .mrw_o(mrw_i), .mrr_o(mrr_i),
      .ma_o(ma_i), .op_o(op_i), .cke_o(cke_i));

   dtvm_regs uut (.clock_i(clock_i), .rst_i(rst_i), .mrw_i(mrw_i),
      .mrr_i(mrr_i), .ma_i(ma_i), .op_i(op_i), .cke_i(cke_i), .ca_i(ca_i),
      .rro_capable_i(rro_capable_i), .temp_rate_i(temp_rate_i),
      .ca_ref_sp0_i(ca_ref_sp0_i), .ca_ref_sp1_i(ca_ref_sp1_i),
      .wr_mask_i(wr_mask_i), .calib_rd_i(calib_rd_i),
      .calib_bit_i(calib_bit_i), .dbi_rd_en_i(dbi_rd_en_i), .dq_o(dq_o),
      .dq_oe_o(dq_oe_o), .mrr_valid_o(mrr_valid_o),
      .lower_mask_inversion_pin_o(pin_o), .rd_dbi_o(rd_dbi_o),
      .command_bus_training_o(cbt_o), .cmd_ignore_o(ign_o),
      .read_preamble_training_o(rpt_o), .reference_level_output_o(vro_o),
      .fast_reference_current_o(fast_o), .mask_disable_o(dmd_o),
      .access_set_point_select_o(asp_o),
      .operating_set_point_select_o(osp_o),
      .dq_reference_level_o(level_o), .dq_reference_range_o(range_o),
      .refresh_rate_o(refresh_rate_o), .wr_mask_o(wr_mask_o));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step();
      @(posedge clock_i);
      #1;
   endtask

   task automatic t_reset();
      chk(ctl, 8'h00);
      chk({range_o, level_o}, 7'h5D);
      m.cmd(1'b0, 6'h0E, 8'h00);
      chk(mrr_valid_o, 1'b1);
      chk(dq_o, 16'h005D);
   endtask

   task automatic t_ctrl();
      for (int i = 0; i < 8; i++) begin
         if (i != 4) begin
            m.cmd(1'b1, 6'h0D, 8'h01 << i);
            chk(ctl, 8'h01 << i);
            chk(ign_o, 1'b0);
         end
      end
      m.cmd(1'b1, 6'h0D, 8'h00);
   endtask

   task automatic t_fsp();
      m.cmd(1'b1, 6'h0D, 8'h40);
      m.cmd(1'b1, 6'h0E, 8'h0A);
      step();
      chk({range_o, level_o}, 7'h5D);
      m.cmd(1'b0, 6'h0E, 8'h00);
      chk(dq_o, 16'h000A);
      m.cmd(1'b1, 6'h0D, 8'h80);
      step();
      chk({range_o, level_o}, 7'h0A);
      m.cmd(1'b0, 6'h0E, 8'h00);
      chk(dq_o, 16'h005D);
      m.cmd(1'b1, 6'h0D, 8'h00);
   endtask

   task automatic t_level();
      m.cmd(1'b1, 6'h0E, 8'h33);
      m.cmd(1'b0, 6'h0E, 8'h00);
      chk(dq_o, 16'h005D);
      m.cmd(1'b1, 6'h0E, 8'h32);
      m.cmd(1'b1, 6'h0E, 8'h73);
      m.cmd(1'b0, 6'h0E, 8'h00);
      chk(dq_o, 16'h0032);
      chk({range_o, level_o}, 7'h32);
   endtask

   task automatic t_rate();
      logic [4:0] k;
      logic [2:0] e;
      for (int i = 0; i < 32; i++) begin
         k = 5'(i);
         m.cmd(1'b1, 6'h0D, {3'h0, k[3], 4'h0});
         @(posedge clock_i);
         rro_capable_i <= k[4];
         temp_rate_i <= k[2:0];
         step();
         e = k[2:0];
         if (k[4] && !k[3] && (e == 3'h1 || e == 3'h2)) begin
            e = 3'h3;
         end
         chk(refresh_rate_o, e);
      end
      m.cmd(1'b1, 6'h0D, 8'h00);
   endtask

   task automatic t_mask();
      @(posedge clock_i);
      wr_mask_i <= 2'h3;
      step();
      chk(wr_mask_o, 2'h3);
      m.cmd(1'b1, 6'h0D, 8'h20);
      step();
      chk(wr_mask_o, 2'h0);
      m.cmd(1'b1, 6'h0D, 8'h00);
   endtask

   task automatic t_calib();
      @(posedge clock_i);
      calib_rd_i <= 1'b1;
      calib_bit_i <= 1'b1;
      dbi_rd_en_i <= 1'b1;
      step();
      chk(dq_o[7:0], 8'hAA);
      chk(pin_o, 1'b1);
      chk(rd_dbi_o, 1'b0);
      m.cmd(1'b1, 6'h0F, 8'h0F);
      @(posedge clock_i);
      calib_bit_i <= 1'b0;
      step();
      chk(dq_o[7:0], 8'h0F);
      chk(pin_o, 1'b0);
      m.cmd(1'b0, 6'h0F, 8'h00);
      chk(mrr_valid_o, 1'b1);
      chk(dq_o, 16'h0000);
      @(posedge clock_i);
      calib_rd_i <= 1'b0;
      step();
      chk(rd_dbi_o, 1'b1);
   endtask

   task automatic t_vro();
      @(posedge clock_i);
      ca_ref_sp0_i <= 7'h11;
      ca_ref_sp1_i <= 7'h22;
      m.cmd(1'b1, 6'h0D, 8'h04);
      step();
      chk(dq_oe_o, 1'b1);
      chk(dq_o, 16'h1132);
      m.cmd(1'b1, 6'h0D, 8'h84);
      step();
      step();
      chk(dq_o, 16'h220A);
      m.cmd(1'b1, 6'h0D, 8'h00);
   endtask

   task automatic t_train();
      @(posedge clock_i);
      ca_i <= 6'h2A;
      m.cmd(1'b1, 6'h0D, 8'h01);
      m.set_cke(1'b0);
      step();
      chk(ign_o, 1'b1);
      chk(dq_o[5:0], 6'h2A);
      m.cmd(1'b1, 6'h0D, 8'h00);
      chk(cbt_o, 1'b1);
      m.leave_training();
      chk(cbt_o, 1'b0);
   endtask

   task automatic summarize();
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_ctrl();
      t_fsp();
      t_level();
      t_rate();
      t_mask();
      t_calib();
      t_vro();
      t_train();
      summarize();
   end

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
